/* verif/sla_mem_model.sv */
`timescale 1ns/100ps
module sla_mem_model #(
   parameter int AW = 8
) (
   input wire logic i_clk,
   input wire logic [AW-1:0] i_addr,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [2**AW];
   initial o_rdata = 8'h00;
   // Read data valid only in the cycle after the read strobe; churns otherwise
   always @(posedge i_clk)
   begin
      if (i_rd)
         o_rdata <= mem[i_addr];
      else
         o_rdata <= ~o_rdata;
      if (i_wr)
         mem[i_addr] <= i_wdata;
   end
endmodule

/* verif/test_shift_logic_alu_ops.sv */
`timescale 1ns/100ps
module test_shift_logic_alu_ops;
   import sla_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic op_valid = 1'b0, op_src = 1'b0, op_dst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   sla_op_t op_code = SLA_OP_AND;
   logic [7:0] op_imm = 8'h00, op_addr = 8'h00, mem_addr, mem_wdata, mem_rdata, wreg;
   logic [3:0] adr = 4'h0, sel = 4'hF, flags;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic [31:0] rdat_w;
   logic ready, done, mem_rd, mem_wr, ack;
   int errors = 0;
   int compares = 0;

   sla_shift_logic_alu DUT (.i_clk(i_clk), .i_rst(i_rst), .i_op_valid(op_valid),
      .i_op_code(op_code), .i_op_mem_src(op_src), .i_op_mem_dst(op_dst), .i_op_imm(op_imm),
      .i_op_addr(op_addr), .o_op_ready(ready), .o_op_done(done), .o_mem_addr(mem_addr),
      .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_wdata(mem_wdata), .i_mem_rdata(mem_rdata),
      .o_working_register(wreg), .o_flags(flags), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat_w),
      .o_wb_ack(ack));
   sla_mem_model mem_i (.i_clk(i_clk), .i_addr(mem_addr), .i_rd(mem_rd), .i_wr(mem_wr),
      .i_wdata(mem_wdata), .o_rdata(mem_rdata));

   initial forever #12.5 i_clk = ~i_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      @(posedge i_clk);
      while (ack !== 1'b1 && n < 50)
      begin
         @(posedge i_clk);
         n++;
      end
      if (ack !== 1'b1)
         errors++;
      rdat = rdat_w;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic op(input sla_op_t c, input logic s, d, input logic [7:0] imm, a);
      int n;
      @(posedge i_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_src <= s;
      op_dst <= d;
      op_imm <= imm;
      op_addr <= a;
      n = 0;
      @(posedge i_clk);
      while (ready !== 1'b1 && n < 50)
      begin
         @(posedge i_clk);
         n++;
      end
      if (ready !== 1'b1)
         errors++;
      op_valid <= 1'b0;
      n = 0;
      @(posedge i_clk);
      while (done !== 1'b1 && n < 50)
      begin
         @(posedge i_clk);
         n++;
      end
      if (done !== 1'b1)
         errors++;
      #1;
   endtask

   task automatic set_state(input logic [7:0] w, input logic [3:0] f);
      wb(1'b1, SLA_OFS_WREG, 32'(w));
      wb(1'b1, SLA_OFS_FLAGS, 32'(f));
   endtask

   task automatic t_reset();
      chk(32'(wreg), 32'h0000_0000);
      chk(32'(flags), 32'h0000_0000);
      wb(1'b0, SLA_OFS_CTRL, 32'h0000_0000);
      chk(rdat, 32'h0000_0001);
      wb(1'b0, 4'h2, 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
      // Disabled block must refuse requests
      wb(1'b1, SLA_OFS_CTRL, 32'h0000_0000);
      repeat (2) @(posedge i_clk);
      #1;
      chk(32'(ready), 32'h0000_0000);
      wb(1'b1, SLA_OFS_CTRL, 32'h0000_0001);
      repeat (2) @(posedge i_clk);
      #1;
      chk(32'(ready), 32'h0000_0001);
      $display("reset test done");
   endtask

   // Four shift kinds, carry in 0 and 1, register or memory in place
   task automatic t_shift(input logic m);
      logic [7:0] w, r;
      logic [3:0] f;
      logic ci, co;
      for (int k = 0; k < 8; k++)
      begin
         ci = k[0];
         w = ci ? 8'h4A : 8'hA5;
         f = 4'b1101 | {2'b00, ci, 1'b0};
         case (k >> 1)
            0: {r, co} = {1'b0, w};
            1: {r, co} = {ci, w};
            2: {co, r} = {w, 1'b0};
            default: {co, r} = {w, ci};
         endcase
         if (m)
         begin
            mem_i.mem[8'h33] = w;
            set_state(8'h77, f);
            op(sla_op_t'(4'(k >> 1)), 1'b1, 1'b1, 8'h00, 8'h33);
            chk(32'(mem_i.mem[8'h33]), 32'(r));
            chk(32'(wreg), 32'h0000_0077);
         end
         else
         begin
            set_state(w, f);
            op(sla_op_t'(4'(k >> 1)), 1'b0, 1'b0, 8'h00, 8'h00);
            chk(32'(wreg), 32'(r));
         end
         chk(32'(flags), 32'({f[3:2], co, f[0]}));
      end
      $display("shift test done, memory=%0d", m);
   endtask

   task automatic t_swap();
      set_state(8'h3C, 4'b1010);
      op(SLA_OP_SWAP, 1'b0, 1'b0, 8'h00, 8'h00);
      chk(32'(wreg), 32'h0000_00C3);
      chk(32'(flags), 32'h0000_000A);
      $display("swap test done");
   endtask

   // AND and OR with immediate, memory to register, memory to memory; XOR with immediate only
   task automatic t_logic();
      logic [7:0] b, r;
      logic s, d;
      for (int c = 5; c < 8; c++)
      begin
         for (int j = 0; j < 3; j++)
         begin
            if (c == 7 && j > 0)
               continue;
            s = j > 0;
            d = j > 1;
            b = (c == 7) ? 8'h0F : 8'hF0;
            r = (c == 5) ? 8'h0F & b : (c == 6) ? 8'h0F | b : 8'h0F ^ b;
            mem_i.mem[8'h21] = b;
            set_state(8'h0F, {3'b111, r != 8'h00});
            op(sla_op_t'(4'(c)), s, d, s ? ~b : b, 8'h21);
            if (d)
            begin
               chk(32'(mem_i.mem[8'h21]), 32'(r));
               chk(32'(wreg), 32'h0000_000F);
            end
            else
               chk(32'(wreg), 32'(r));
            chk(32'(flags), 32'({3'b111, r == 8'h00}));
         end
      end
      $display("logic test done");
   endtask

   task automatic t_illegal();
      set_state(8'h12, 4'h5);
      op(SLA_OP_XOR, 1'b1, 1'b1, 8'hFF, 8'h21);
      chk(32'(wreg), 32'h0000_0012);
      chk(32'(flags), 32'h0000_0005);
      wb(1'b0, SLA_OFS_STATUS, 32'h0000_0000);
      chk(32'(rdat[SLA_STAT_ERR]), 32'h0000_0001);
      chk(32'(rdat[SLA_STAT_OP_LSB +: 4]), 32'h0000_0007);
      // Error bit clears on a written one
      wb(1'b1, SLA_OFS_STATUS, 32'h0000_0002);
      wb(1'b0, SLA_OFS_STATUS, 32'h0000_0000);
      chk(32'(rdat[SLA_STAT_ERR]), 32'h0000_0000);
      $display("illegal op test done");
   endtask

   initial
   begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      t_reset();
      t_shift(1'b0);
      t_shift(1'b1);
      t_swap();
      t_logic();
      t_illegal();
      conclude();
   end

   initial
   begin
      #(25 * 20000);
      errors++;
      conclude();
   end
endmodule

/* verilog/sla_pkg.sv */
package sla_pkg;

   // Datapath and bus widths
   localparam int SLA_DW = 8;
   localparam int SLA_WB_AW = 4;
   localparam int SLA_WB_DW = 32;
   localparam int SLA_FLAG_W = 4;

   // Register byte offsets
   localparam logic [SLA_WB_AW-1:0] SLA_OFS_CTRL = 4'h0;
   localparam logic [SLA_WB_AW-1:0] SLA_OFS_WREG = 4'h4;
   localparam logic [SLA_WB_AW-1:0] SLA_OFS_FLAGS = 4'h8;
   localparam logic [SLA_WB_AW-1:0] SLA_OFS_STATUS = 4'hC;

   // Flag register layout
   localparam int SLA_FLG_ZERO = 0;
   localparam int SLA_FLG_CARRY = 1;
   localparam int SLA_FLG_HALF_CARRY = 2;
   localparam int SLA_FLG_SIGNED_EXCESS = 3;

   // Control and status fields
   localparam int SLA_CTRL_EN = 0;
   localparam int SLA_STAT_BUSY = 0;
   localparam int SLA_STAT_ERR = 1;
   localparam int SLA_STAT_OP_LSB = 4;

   // Reset values
   localparam logic SLA_EN_RST = 1'b1;
   localparam logic [SLA_DW-1:0] SLA_WREG_RST = 8'h00;
   localparam logic [SLA_FLAG_W-1:0] SLA_FLAGS_RST = 4'h0;

   typedef enum logic [3:0] {
      SLA_OP_SHIFT_RIGHT_LOGICAL = 4'b0000,
      SLA_OP_ROTATE_RIGHT = 4'b0001,
      SLA_OP_SHIFT_LEFT_LOGICAL = 4'b0010,
      SLA_OP_ROTATE_LEFT = 4'b0011,
      SLA_OP_SWAP = 4'b0100,
      SLA_OP_AND = 4'b0101,
      SLA_OP_OR = 4'b0110,
      SLA_OP_XOR = 4'b0111
   } sla_op_t;

   typedef enum logic [1:0] {
      SLA_ST_IDLE = 2'b00,
      SLA_ST_READ = 2'b01,
      SLA_ST_DATA = 2'b10,
      SLA_ST_WRITE = 2'b11
   } sla_state_t;

endpackage

/* verilog/sla_shift_logic_alu.sv */
`timescale 1ns/100ps

// Functional notes
// - Register logical right shift: bits move down, bit 7 gets 0, carry gets old bit 0.
// - Register right rotate: bits move down, old carry enters bit 7, carry gets bit 0.
// - Memory logical right shift: result bit 7 is 0, carry gets old bit 0.
// - Memory right rotate: written byte has old carry at bit 7, carry from bit 0.
// - Register logical left shift: bits move up, bit 0 gets 0, carry gets old bit 7.
// - Register left rotate: bits move up, old carry enters bit 0, carry gets bit 7.
// - Memory logical left shift: result bit 0 is 0, carry gets old bit 7.
// - Memory left rotate: written byte has old carry at bit 0, carry from bit 7.
// - Shifts and rotates change only carry; zero, half carry, excess flags kept.
// - Nibble swap exchanges high and low halves of register; no flag changes.
// - AND register with immediate byte, result to register.
// - AND register with memory byte, result to register or back to memory.
// - OR register with immediate byte, result to register.
// - OR register with memory byte, result to register or back to memory.
// - XOR register with immediate byte, result to register.
// - AND, OR, XOR update zero flag only; other flags kept.
module sla_shift_logic_alu #(
   parameter int MEM_AW = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Operation request from decoder
   input wire logic i_op_valid,
   input wire sla_pkg::sla_op_t i_op_code,
   input wire logic i_op_mem_src,
   input wire logic i_op_mem_dst,
   input wire logic [sla_pkg::SLA_DW-1:0] i_op_imm,
   input wire logic [MEM_AW-1:0] i_op_addr,
   output logic o_op_ready,
   output logic o_op_done,
   // Data memory port
   output logic [MEM_AW-1:0] o_mem_addr,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic [sla_pkg::SLA_DW-1:0] o_mem_wdata,
   input wire logic [sla_pkg::SLA_DW-1:0] i_mem_rdata,
   // Working register and flags
   output logic [sla_pkg::SLA_DW-1:0] o_working_register,
   output logic [sla_pkg::SLA_FLAG_W-1:0] o_flags,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [sla_pkg::SLA_WB_AW-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [sla_pkg::SLA_WB_DW-1:0] i_wb_dat,
   output logic [sla_pkg::SLA_WB_DW-1:0] o_wb_dat,
   output logic o_wb_ack
);
   import sla_pkg::*;

   sla_state_t state_reg;
   sla_op_t op_reg;
   sla_op_t last_op_reg;
   sla_op_t calc_op;
   logic dst_mem_reg;
   logic [MEM_AW-1:0] mem_addr_reg;
   logic mem_rd_reg;
   logic mem_wr_reg;
   logic [SLA_DW-1:0] mem_wdata_reg;
   logic done_reg;
   logic ready_reg;
   logic [SLA_DW-1:0] working_register_reg;
   logic [SLA_FLAG_W-1:0] flags_reg;
   logic en_reg;
   logic err_reg;
   logic wb_ack_reg;
   logic [SLA_WB_DW-1:0] wb_dat_reg;
   logic [SLA_WB_DW-1:0] wb_rd_next;
   logic wb_wr;
   logic take;
   logic legal;
   logic compute_now;
   logic commit_reg_now;
   logic [SLA_DW-1:0] calc_x;
   logic [SLA_DW-1:0] calc_y;
   logic [SLA_DW:0] calc_out;
   logic [SLA_FLAG_W-1:0] flags_next;

   // Helper state for checking only
   logic [SLA_DW-1:0] chk_x_reg;
   logic [SLA_DW-1:0] chk_y_reg;
   logic [SLA_FLAG_W-1:0] chk_flags_reg;
   sla_op_t chk_op_reg;
   logic chk_mem_reg;
   logic chk_live_reg;

   function automatic logic is_shift(input sla_op_t op);
      is_shift = (op == SLA_OP_SHIFT_RIGHT_LOGICAL) || (op == SLA_OP_ROTATE_RIGHT) ||
                 (op == SLA_OP_SHIFT_LEFT_LOGICAL) || (op == SLA_OP_ROTATE_LEFT);
   endfunction

   function automatic logic is_logic(input sla_op_t op);
      is_logic = (op == SLA_OP_AND) || (op == SLA_OP_OR) || (op == SLA_OP_XOR);
   endfunction

   // Shifts are read-modify-write on one place; XOR and swap take no memory
   function automatic logic op_legal(input sla_op_t op, input logic src, input logic dst);
      if (is_shift(op))
      begin
         op_legal = (src == dst);
      end
      else if ((op == SLA_OP_AND) || (op == SLA_OP_OR))
      begin
         op_legal = !(dst && !src);
      end
      else if ((op == SLA_OP_XOR) || (op == SLA_OP_SWAP))
      begin
         op_legal = !src && !dst;
      end
      else
      begin
         op_legal = 1'b0;
      end
   endfunction

   // Returns {carry, result}
   function automatic logic [SLA_DW:0] alu_calc(input sla_op_t op, input logic [SLA_DW-1:0] x,
                                                input logic [SLA_DW-1:0] y, input logic cin);
      case (op)
         SLA_OP_SHIFT_RIGHT_LOGICAL: alu_calc = {x[0], 1'b0, x[7:1]};
         SLA_OP_ROTATE_RIGHT: alu_calc = {x[0], cin, x[7:1]};
         SLA_OP_SHIFT_LEFT_LOGICAL: alu_calc = {x[7], x[6:0], 1'b0};
         SLA_OP_ROTATE_LEFT: alu_calc = {x[7], x[6:0], cin};
         SLA_OP_SWAP: alu_calc = {cin, x[3:0], x[7:4]};
         SLA_OP_AND: alu_calc = {cin, x & y};
         SLA_OP_OR: alu_calc = {cin, x | y};
         SLA_OP_XOR: alu_calc = {cin, x ^ y};
         default: alu_calc = {cin, x};
      endcase
   endfunction

   function automatic logic [SLA_FLAG_W-1:0] flags_after(input sla_op_t op,
                                                         input logic [SLA_FLAG_W-1:0] f,
                                                         input logic [SLA_DW:0] r);
      flags_after = f;
      if (is_shift(op))
      begin
         flags_after[SLA_FLG_CARRY] = r[SLA_DW];
      end
      else if (is_logic(op))
      begin
         flags_after[SLA_FLG_ZERO] = (r[SLA_DW-1:0] == 8'h00);
      end
   endfunction

   always_comb
   begin
      take = i_op_valid && ready_reg && (state_reg == SLA_ST_IDLE);
      legal = op_legal(i_op_code, i_op_mem_src, i_op_mem_dst);
      calc_op = (state_reg == SLA_ST_DATA) ? op_reg : i_op_code;
      calc_y = (state_reg == SLA_ST_DATA) ? i_mem_rdata : i_op_imm;
      if ((state_reg == SLA_ST_DATA) && is_shift(op_reg))
      begin
         calc_x = i_mem_rdata;
      end
      else
      begin
         calc_x = working_register_reg;
      end
      calc_out = alu_calc(calc_op, calc_x, calc_y, flags_reg[SLA_FLG_CARRY]);
      flags_next = flags_after(calc_op, flags_reg, calc_out);
      compute_now = (take && legal && !i_op_mem_src) || (state_reg == SLA_ST_DATA);
      commit_reg_now = compute_now && !((state_reg == SLA_ST_DATA) && dst_mem_reg);
   end

   // Working register; datapath has priority over software
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         working_register_reg <= SLA_WREG_RST;
      end
      else if (commit_reg_now)
      begin
         working_register_reg <= calc_out[SLA_DW-1:0];
      end
      else if (wb_wr && (i_wb_adr == SLA_OFS_WREG) && i_wb_sel[0])
      begin
         working_register_reg <= i_wb_dat[SLA_DW-1:0];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         flags_reg <= SLA_FLAGS_RST;
      end
      else if (compute_now)
      begin
         flags_reg <= flags_next;
      end
      else if (wb_wr && (i_wb_adr == SLA_OFS_FLAGS) && i_wb_sel[0])
      begin
         flags_reg <= i_wb_dat[SLA_FLAG_W-1:0];
      end
   end

   // Operation sequencer
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_reg <= SLA_ST_IDLE;
         op_reg <= SLA_OP_SHIFT_RIGHT_LOGICAL;
         dst_mem_reg <= 1'b0;
         mem_addr_reg <= '0;
         mem_rd_reg <= 1'b0;
         mem_wr_reg <= 1'b0;
         mem_wdata_reg <= 8'h00;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         case (state_reg)
            SLA_ST_IDLE:
            begin
               if (take && legal && i_op_mem_src)
               begin
                  op_reg <= i_op_code;
                  dst_mem_reg <= i_op_mem_dst;
                  mem_addr_reg <= i_op_addr;
                  mem_rd_reg <= 1'b1;
                  state_reg <= SLA_ST_READ;
               end
               else if (take)
               begin
                  done_reg <= 1'b1;
               end
            end
            SLA_ST_READ:
            begin
               mem_rd_reg <= 1'b0;
               state_reg <= SLA_ST_DATA;
            end
            SLA_ST_DATA:
            begin
               if (dst_mem_reg)
               begin
                  mem_wr_reg <= 1'b1;
                  mem_wdata_reg <= calc_out[SLA_DW-1:0];
                  state_reg <= SLA_ST_WRITE;
               end
               else
               begin
                  done_reg <= 1'b1;
                  state_reg <= SLA_ST_IDLE;
               end
            end
            SLA_ST_WRITE:
            begin
               mem_wr_reg <= 1'b0;
               done_reg <= 1'b1;
               state_reg <= SLA_ST_IDLE;
            end
            default:
            begin
               state_reg <= SLA_ST_IDLE;
            end
         endcase
      end
   end

   // Ready only in idle with the enable bit set
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ready_reg <= 1'b0;
      end
      else
      begin
         ready_reg <= (state_reg == SLA_ST_IDLE) && !take && en_reg;
      end
   end

   // Error sticky: set wins over software clear
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         err_reg <= 1'b0;
      end
      else if (take && !legal)
      begin
         err_reg <= 1'b1;
      end
      else if (wb_wr && (i_wb_adr == SLA_OFS_STATUS) && i_wb_sel[0] && i_wb_dat[SLA_STAT_ERR])
      begin
         err_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         last_op_reg <= SLA_OP_SHIFT_RIGHT_LOGICAL;
      end
      else if (take)
      begin
         last_op_reg <= i_op_code;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         en_reg <= SLA_EN_RST;
      end
      else if (wb_wr && (i_wb_adr == SLA_OFS_CTRL) && i_wb_sel[0])
      begin
         en_reg <= i_wb_dat[SLA_CTRL_EN];
      end
   end

   // Wishbone: one wait state, unmapped reads zero, writes land on the ack edge
   always_comb
   begin
      wb_wr = i_wb_cyc && i_wb_stb && i_wb_we && wb_ack_reg;
      wb_rd_next = 32'h0000_0000;
      case (i_wb_adr)
         SLA_OFS_CTRL: wb_rd_next[SLA_CTRL_EN] = en_reg;
         SLA_OFS_WREG: wb_rd_next[SLA_DW-1:0] = working_register_reg;
         SLA_OFS_FLAGS: wb_rd_next[SLA_FLAG_W-1:0] = flags_reg;
         SLA_OFS_STATUS:
         begin
            wb_rd_next[SLA_STAT_BUSY] = (state_reg != SLA_ST_IDLE);
            wb_rd_next[SLA_STAT_ERR] = err_reg;
            wb_rd_next[SLA_STAT_OP_LSB +: 4] = last_op_reg;
         end
         default: wb_rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wb_ack_reg <= 1'b0;
         wb_dat_reg <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_reg <= i_wb_cyc && i_wb_stb && !wb_ack_reg;
         if (i_wb_cyc && i_wb_stb && !i_wb_we && !wb_ack_reg)
         begin
            wb_dat_reg <= wb_rd_next;
         end
      end
   end

   // Operand capture for checks
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         chk_x_reg <= 8'h00;
         chk_y_reg <= 8'h00;
         chk_flags_reg <= 4'h0;
         chk_op_reg <= SLA_OP_SHIFT_RIGHT_LOGICAL;
         chk_mem_reg <= 1'b0;
         chk_live_reg <= 1'b0;
      end
      else if (compute_now)
      begin
         chk_x_reg <= calc_x;
         chk_y_reg <= calc_y;
         chk_flags_reg <= flags_reg;
         chk_op_reg <= calc_op;
         chk_mem_reg <= (state_reg == SLA_ST_DATA) && dst_mem_reg;
         chk_live_reg <= 1'b1;
      end
      else if (take)
      begin
         chk_live_reg <= 1'b0;
      end
   end

   assign o_op_ready = ready_reg;
   assign o_op_done = done_reg;
   assign o_mem_addr = mem_addr_reg;
   assign o_mem_rd = mem_rd_reg;
   assign o_mem_wr = mem_wr_reg;
   assign o_mem_wdata = mem_wdata_reg;
   assign o_working_register = working_register_reg;
   assign o_flags = flags_reg;
   assign o_wb_dat = wb_dat_reg;
   assign o_wb_ack = wb_ack_reg;

   a_shr_reg_result: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && !chk_mem_reg && chk_op_reg == SLA_OP_SHIFT_RIGHT_LOGICAL
      |-> o_working_register == {1'b0, chk_x_reg[7:1]} && o_flags[SLA_FLG_CARRY] == chk_x_reg[0])
      else $error("logical right shift of register wrong");

   a_rotr_reg_result: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && !chk_mem_reg && chk_op_reg == SLA_OP_ROTATE_RIGHT
      |-> o_working_register == {chk_flags_reg[SLA_FLG_CARRY], chk_x_reg[7:1]}
      && o_flags[SLA_FLG_CARRY] == chk_x_reg[0])
      else $error("right rotate of register wrong");

   a_shr_mem_write: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_mem_wr) && chk_op_reg == SLA_OP_SHIFT_RIGHT_LOGICAL
      |-> o_mem_wdata == {1'b0, chk_x_reg[7:1]} && o_flags[SLA_FLG_CARRY] == chk_x_reg[0])
      else $error("logical right shift of memory wrong");

   a_rotr_mem_write: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_mem_wr) && chk_op_reg == SLA_OP_ROTATE_RIGHT
      |-> o_mem_wdata == {chk_flags_reg[SLA_FLG_CARRY], chk_x_reg[7:1]}
      && o_flags[SLA_FLG_CARRY] == chk_x_reg[0])
      else $error("right rotate of memory wrong");

   a_shl_reg_result: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && !chk_mem_reg && chk_op_reg == SLA_OP_SHIFT_LEFT_LOGICAL
      |-> o_working_register == {chk_x_reg[6:0], 1'b0} && o_flags[SLA_FLG_CARRY] == chk_x_reg[7])
      else $error("logical left shift of register wrong");

   a_rotl_reg_result: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && !chk_mem_reg && chk_op_reg == SLA_OP_ROTATE_LEFT
      |-> o_working_register == {chk_x_reg[6:0], chk_flags_reg[SLA_FLG_CARRY]}
      && o_flags[SLA_FLG_CARRY] == chk_x_reg[7])
      else $error("left rotate of register wrong");

   a_shl_mem_write: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_mem_wr) && chk_op_reg == SLA_OP_SHIFT_LEFT_LOGICAL
      |-> o_mem_wdata == {chk_x_reg[6:0], 1'b0} && o_flags[SLA_FLG_CARRY] == chk_x_reg[7])
      else $error("logical left shift of memory wrong");

   a_rotl_mem_write: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_mem_wr) && chk_op_reg == SLA_OP_ROTATE_LEFT
      |-> o_mem_wdata == {chk_x_reg[6:0], chk_flags_reg[SLA_FLG_CARRY]}
      && o_flags[SLA_FLG_CARRY] == chk_x_reg[7])
      else $error("left rotate of memory wrong");

   a_shift_other_flags: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && is_shift(chk_op_reg)
      |-> o_flags[SLA_FLG_ZERO] == chk_flags_reg[SLA_FLG_ZERO]
      && o_flags[SLA_FLG_HALF_CARRY] == chk_flags_reg[SLA_FLG_HALF_CARRY]
      && o_flags[SLA_FLG_SIGNED_EXCESS] == chk_flags_reg[SLA_FLG_SIGNED_EXCESS])
      else $error("shift disturbed a flag other than carry");

   a_swap_nibbles: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && chk_op_reg == SLA_OP_SWAP
      |-> o_working_register == {chk_x_reg[3:0], chk_x_reg[7:4]} && o_flags == chk_flags_reg)
      else $error("nibble swap wrong");

   a_and_reg_result: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && !chk_mem_reg && chk_op_reg == SLA_OP_AND
      |-> o_working_register == (chk_x_reg & chk_y_reg))
      else $error("AND into register wrong");

   a_and_mem_write: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_mem_wr) && chk_op_reg == SLA_OP_AND
      |-> o_mem_wdata == (chk_x_reg & chk_y_reg) && $stable(o_working_register))
      else $error("AND into memory wrong");

   a_or_reg_result: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && !chk_mem_reg && chk_op_reg == SLA_OP_OR
      |-> o_working_register == (chk_x_reg | chk_y_reg))
      else $error("OR into register wrong");

   a_or_mem_write: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_mem_wr) && chk_op_reg == SLA_OP_OR
      |-> o_mem_wdata == (chk_x_reg | chk_y_reg))
      else $error("OR into memory wrong");

   a_xor_reg_result: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && chk_op_reg == SLA_OP_XOR
      |-> o_working_register == (chk_x_reg ^ chk_y_reg))
      else $error("XOR into register wrong");

   a_logic_flags_kept: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && is_logic(chk_op_reg)
      |-> o_flags[3:1] == chk_flags_reg[3:1])
      else $error("logic operation disturbed carry, half carry or excess");

   a_zero_flag_value: assert property (@(posedge i_clk) disable iff (i_rst)
      o_op_done && chk_live_reg && is_logic(chk_op_reg) && !chk_mem_reg
      |-> o_flags[SLA_FLG_ZERO] == (o_working_register == 8'h00))
      else $error("zero flag does not match result");

   a_mem_rmw_order: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_mem_rd) |-> ##[2:3] o_op_done ##0 ($past(o_mem_addr) == o_mem_addr))
      else $error("memory operation did not finish in time at same address");

endmodule
